// ===== rtl/vgdc_pkg.sv
// Purpose: Shared constants for the legacy VGA decode and clock control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Destination codes are one-hot per target
package vgdc_pkg;

  localparam logic [7:0] VGDC_CLKCTL_OFS   = 8'h60;
  localparam logic [7:0] VGDC_CTL_OFS      = 8'h61;
  localparam logic [7:0] VGDC_STAT_OFS     = 8'h62;
  localparam logic [7:0] VGDC_CLKCTL_RST   = 8'h00;
  localparam logic [7:0] VGDC_CTL_RST      = 8'h08;
  localparam logic [4:0] VGDC_CLKCTL_WMASK = 5'h1f;

  localparam int VGDC_BIT_GMCLK = 0;
  localparam int VGDC_BIT_PSYNC = 1;
  localparam int VGDC_BIT_PROP  = 2;
  localparam int VGDC_BIT_ACT   = 3;
  localparam int VGDC_BIT_DLL   = 4;

  // Control register fields
  localparam int VGDC_CTL_VGADIS = 1;
  localparam int VGDC_CTL_GDIS   = 3;

  // Legacy memory ranges, address bits 19:15 (32 KB units)
  localparam logic [4:0] VGDC_MEM_A0  = 5'h14;
  localparam logic [4:0] VGDC_MEM_A8  = 5'h15;
  localparam logic [4:0] VGDC_MEM_B0  = 5'h16;
  localparam logic [4:0] VGDC_MEM_B8  = 5'h17;

  // Legacy I/O ports
  localparam logic [15:0] VGDC_IO_3B0 = 16'h03b0;
  localparam logic [15:0] VGDC_IO_3BB = 16'h03bb;
  localparam logic [15:0] VGDC_IO_3BC = 16'h03bc;
  localparam logic [15:0] VGDC_IO_3BE = 16'h03be;
  localparam logic [15:0] VGDC_IO_3BF = 16'h03bf;
  localparam logic [15:0] VGDC_IO_3C0 = 16'h03c0;
  localparam logic [15:0] VGDC_IO_3CF = 16'h03cf;
  localparam logic [15:0] VGDC_IO_3D0 = 16'h03d0;
  localparam logic [15:0] VGDC_IO_3DF = 16'h03df;
  localparam logic [15:0] VGDC_IO_3B4 = 16'h03b4;
  localparam logic [15:0] VGDC_IO_3B5 = 16'h03b5;
  localparam logic [15:0] VGDC_IO_3B8 = 16'h03b8;
  localparam logic [15:0] VGDC_IO_3BA = 16'h03ba;

  typedef enum logic [2:0] {
    VGDC_DST_NONE = 3'b000,
    VGDC_DST_GFX  = 3'b001,
    VGDC_DST_AGP  = 3'b010,
    VGDC_DST_HUB  = 3'b100
  } vgdc_dst_t;

endpackage

// ===== rtl/vgdc_router.sv
// Contract
// R01 - Claim order: graphics unit, then bridge, then hub link.
// R02 - Graphics memory claim needs enable, no VGA disable, space enable, D0, ram bit.
// R03 - Field bits 3:2 pick which memory windows graphics claims.
// R04 - Failed graphics memory claim with bridge memory enable uses legacy decode.
// R05 - Legacy memory: forward and mono bits choose hub or AGP per range.
// R06 - Otherwise legacy memory and I/O cycles go to the hub link.
// R07 - Graphics I/O claim needs enable, no VGA disable, I/O enable, D0.
// R08 - 3Cx always graphics, 3BC-3BF never; io select swaps 3Bx and 3Dx.
// R09 - Failed graphics I/O claim with bridge I/O enable uses legacy decode.
// R10 - No forward, no mono: hub, but 3BC-3BF to AGP without ISA enable.
// R11 - Forward only: VGA ports to AGP, other ports to hub.
// R12 - Both set: VGA ports AGP, mono ports and 3BC-3BE to hub.
// R13 - Clock control at 60h, eight bits, reset 00h, bits 7:5 reserved.
// R14 - Bit 4 stops memory clocks from DLL; clear restores them cleanly.
// R15 - Software writes clock gate bits before the divider sync bit.
// R16 - Activate bit releases graphics reset once enabled; only reset re-arms.
// R17 - Propagate bit after disable cleared swaps config spaces, enables graphics clock.
// R18 - Writing 0 to propagate does nothing; software clears it soon after.
// R19 - Sync bit 1 resets PLL dividers and loads memory and test settings.
// R20 - Sync bit falling makes PLL align memory and core clocks to CPU.
// R21 - Bit 0 stops graphics and memory clocks cleanly; clear restarts them.
// R22 - VGA disable clear lets graphics claim cycles; set claims none.
// R23 - Illegal mono-only setting routes cycles to the hub link.
//
// Purpose: Routes legacy VGA cycles and sequences graphics clock control
// Assumes: Decode inputs share clk_sys; clock gates toggle only on clk_sys
// Notes:   Route answer registered one cycle after cyc_valid
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module vgdc_router
  import vgdc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        cyc_valid,
  input  wire logic        cyc_is_io,
  input  wire logic [19:0] cyc_addr,
  input  wire logic        gfx_mem_space_en,
  input  wire logic        gfx_io_space_en,
  input  wire logic        gfx_in_d0,
  input  wire logic        misc_output_ram_bit,
  input  wire logic        misc_output_io_select,
  input  wire logic [1:0]  graphics_misc_field,
  input  wire logic        bridge_mem_space_en,
  input  wire logic        bridge_io_space_en,
  input  wire logic        bridge_vga_forward,
  input  wire logic        mono_adapter_present,
  input  wire logic        bridge_isa_enable,
  output logic             route_valid,
  output logic [2:0]       route_dst,
  output logic             mem_dll_clk_en,
  output logic             gfx_mem_clk_en,
  output logic             gfx_core_clk_en,
  output logic             gfx_reset_n,
  output logic             bridge_cfg_visible,
  output logic             gfx_cfg_visible,
  output logic             pll_div_reset,
  output logic             pll_sync_pulse
);

  // Clock control and control registers
  logic [4:0]  clkctl_q;
  logic [4:0]  clkctl_d;
  logic [7:0]  ctl_q;
  logic [7:0]  ctl_d;

  // Sequencing flags
  logic        enabled_q;
  logic        enabled_d;
  logic        active_q;
  logic        active_d;
  logic        bvis_q;
  logic        bvis_d;
  logic        sync_q;
  logic        sync_d;
  logic        pulse_q;
  logic        pulse_d;
  logic        dll_en_q;
  logic        dll_en_d;
  logic        gm_en_q;
  logic        gm_en_d;

  // Readback and route registers
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        rv_q;
  logic        rv_d;
  logic [2:0]  dst_q;
  logic [2:0]  dst_d;

  // Register write decode
  logic        wr_clkctl;
  logic        wr_ctl;
  logic        prop_req;
  logic        act_req;

  // Memory decode terms
  logic [4:0]  mseg;
  logic        seg_a0;
  logic        seg_a8;
  logic        seg_b0;
  logic        seg_b8;
  logic        vga_mem;
  logic        mono_mem;
  logic        gfx_mem_hit;
  logic        gfx_mem_claim;
  logic        leg_mem_agp;

  // I/O decode terms
  logic [15:0] port;
  logic        p3cx;
  logic        p3dx;
  logic        p3b0;
  logic        p3bc;
  logic        p3bc_e;
  logic        vga_io;
  logic        mono_io;
  logic        gfx_io_hit;
  logic        gfx_io_claim;
  logic        leg_io_agp;

  // Shared decode terms
  logic        gfx_ok;
  logic        leg_off;
  logic        leg_fwd;
  logic        leg_both;
  vgdc_dst_t   dst;

  assign mseg = cyc_addr[19:15];
  assign port = cyc_addr[15:0];

  assign gfx_ok = enabled_q
                  && !ctl_q[VGDC_CTL_VGADIS]
                  && gfx_in_d0; // R22

  // Register write strobes
  always_comb begin
    wr_clkctl = reg_wr && (reg_addr == VGDC_CLKCTL_OFS);
    wr_ctl    = reg_wr && (reg_addr == VGDC_CTL_OFS);
    // Propagate only on a 1 with disable already clear
    prop_req  = wr_clkctl
                && reg_wdata[VGDC_BIT_PROP]
                && !ctl_q[VGDC_CTL_GDIS]; // R17 R18
    // Activate needs the enable already propagated
    act_req   = wr_clkctl && reg_wdata[VGDC_BIT_ACT] && enabled_q; // R16
  end

  // Clock control register
  always_comb begin
    clkctl_d = clkctl_q;
    if (wr_clkctl) begin
      clkctl_d = reg_wdata[4:0] & VGDC_CLKCTL_WMASK; // R13
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clkctl_q <= VGDC_CLKCTL_RST[4:0]; // R13
    end else begin
      clkctl_q <= clkctl_d;
    end
  end

  // Control register: graphics disable and VGA disable
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = reg_wdata & 8'h0a;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_q <= VGDC_CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Graphics enable and activate, sticky until rst
  always_comb begin
    enabled_d = enabled_q;
    active_d  = active_q;
    if (prop_req) begin
      enabled_d = 1'b1; // R17
    end
    if (act_req) begin
      active_d = 1'b1; // R16
    end
    bvis_d = ~enabled_d; // R17
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enabled_q <= 1'b0;
      active_q  <= 1'b0;
      bvis_q    <= 1'b1;
    end else begin
      enabled_q <= enabled_d;
      active_q  <= active_d;
      bvis_q    <= bvis_d;
    end
  end

  // Gates follow the write at a clk_sys edge, so no glitch
  always_comb begin
    dll_en_d = ~clkctl_d[VGDC_BIT_DLL]; // R14
    gm_en_d  = ~clkctl_d[VGDC_BIT_GMCLK]; // R21
  end

  // Clocks run out of reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dll_en_q <= 1'b1;
      gm_en_q  <= 1'b1;
    end else begin
      dll_en_q <= dll_en_d;
      gm_en_q  <= gm_en_d;
    end
  end

  // Divider sync pulse, one cycle after the sync bit falls
  always_comb begin
    sync_d  = clkctl_q[VGDC_BIT_PSYNC];
    pulse_d = sync_q && !clkctl_q[VGDC_BIT_PSYNC]; // R20
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      pulse_q <= pulse_d;
    end
  end

  // Readback, data stands for one cycle only
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      // Reserved bits 7:5 and unmapped offsets read 0
      unique case (reg_addr)
        VGDC_CLKCTL_OFS: rdata_d = {3'b000, clkctl_q}; // R13
        VGDC_CTL_OFS:    rdata_d = ctl_q;
        VGDC_STAT_OFS:   rdata_d = {6'h00, active_q, enabled_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs are flops or single flop bits
  assign reg_rdata          = rdata_q;
  assign mem_dll_clk_en     = dll_en_q;
  assign gfx_mem_clk_en     = gm_en_q;
  assign gfx_core_clk_en    = enabled_q; // R17
  assign gfx_reset_n        = active_q; // R16
  assign bridge_cfg_visible = bvis_q; // R17
  assign gfx_cfg_visible    = enabled_q;
  assign pll_div_reset      = clkctl_q[VGDC_BIT_PSYNC]; // R19
  assign pll_sync_pulse     = pulse_q; // R20
  assign route_valid        = rv_q;
  assign route_dst          = dst_q;

  // Legacy modes; mono-only matches none and falls to hub
  always_comb begin
    leg_off  = !bridge_vga_forward && !mono_adapter_present;
    leg_fwd  = bridge_vga_forward && !mono_adapter_present;
    leg_both = bridge_vga_forward && mono_adapter_present;
  end

  // Legacy memory decode
  always_comb begin
    // Segments are 32 KB, address bits 19:15
    seg_a0 = (mseg == VGDC_MEM_A0);
    seg_a8 = (mseg == VGDC_MEM_A8);
    seg_b0 = (mseg == VGDC_MEM_B0);
    seg_b8 = (mseg == VGDC_MEM_B8);
    vga_mem  = seg_a0 || seg_a8 || seg_b0 || seg_b8; // R04
    mono_mem = seg_b0; // R04
    gfx_mem_hit = 1'b0;
    unique case (graphics_misc_field) // R03
      2'b00: gfx_mem_hit = vga_mem;
      2'b01: gfx_mem_hit = seg_a0 || seg_a8;
      2'b10: gfx_mem_hit = seg_b0;
      2'b11: gfx_mem_hit = seg_b8;
    endcase
    gfx_mem_claim = gfx_ok
                    && gfx_mem_space_en
                    && misc_output_ram_bit
                    && gfx_mem_hit; // R02
    leg_mem_agp = bridge_mem_space_en
                  && vga_mem
                  && (leg_fwd || (leg_both && !mono_mem)); // R04 R05
  end

  // Legacy I/O decode
  always_comb begin
    p3cx   = (port >= VGDC_IO_3C0) && (port <= VGDC_IO_3CF);
    p3dx   = (port >= VGDC_IO_3D0) && (port <= VGDC_IO_3DF);
    p3b0   = (port >= VGDC_IO_3B0) && (port <= VGDC_IO_3BB);
    p3bc   = (port >= VGDC_IO_3BC) && (port <= VGDC_IO_3BF);
    p3bc_e = (port >= VGDC_IO_3BC) && (port <= VGDC_IO_3BE);
    vga_io = p3b0 || p3cx || p3dx; // R09
    mono_io = (port == VGDC_IO_3B4)
              || (port == VGDC_IO_3B5)
              || ((port >= VGDC_IO_3B8) && (port <= VGDC_IO_3BA))
              || (port == VGDC_IO_3BF); // R09
    // 3Cx always, 3Bx or 3Dx by the io select bit
    gfx_io_hit = p3cx || (misc_output_io_select ? p3dx : p3b0); // R08
    gfx_io_claim = gfx_ok
                   && gfx_io_space_en
                   && gfx_io_hit; // R07
    // Bridge claims only with its I/O space enable
    leg_io_agp = 1'b0;
    if (bridge_io_space_en) begin
      if (leg_off) begin
        leg_io_agp = p3bc && !bridge_isa_enable; // R10
      end else if (leg_fwd) begin
        leg_io_agp = vga_io; // R11
      end else if (leg_both) begin
        leg_io_agp = vga_io && !mono_io && !p3bc_e; // R12
      end
    end
  end

  // Graphics first, bridge second, hub last
  always_comb begin
    dst = VGDC_DST_HUB; // R06 R23
    if (!cyc_is_io) begin
      if (gfx_mem_claim) begin // R01
        dst = VGDC_DST_GFX;
      end else if (leg_mem_agp) begin // R01 R04
        dst = VGDC_DST_AGP;
      end
    end else begin
      if (gfx_io_claim) begin // R01
        dst = VGDC_DST_GFX;
      end else if (leg_io_agp) begin // R01 R09
        dst = VGDC_DST_AGP;
      end
    end
    // Destination rests at none between cycles
    rv_d  = cyc_valid;
    dst_d = cyc_valid ? dst : VGDC_DST_NONE;
  end

  // Route answer one cycle after cyc_valid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rv_q  <= 1'b0;
      dst_q <= VGDC_DST_NONE;
    end else begin
      rv_q  <= rv_d;
      dst_q <= dst_d;
    end
  end

endmodule
`default_nettype wire

// ===== bench/vgdc_host_model.sv
// Purpose: Host model issuing legacy memory and I/O cycles
// Assumes: One cycle per go pulse
// Notes:   Idle lines toggle instead of holding
`timescale 1ns/1ps
`default_nettype none
module vgdc_host_model (
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic        io,
  input  wire logic [19:0] addr,
  output logic             cyc_valid,
  output logic             cyc_is_io,
  output logic      [19:0] cyc_addr
);
  initial begin
    cyc_valid = 1'b0;
    cyc_is_io = 1'b0;
    cyc_addr = 20'h0_0000;
  end
  always @(posedge clk_sys) begin
    cyc_valid <= go;
    cyc_is_io <= go ? io : ~cyc_is_io;
    cyc_addr <= go ? addr : ~cyc_addr;
  end
endmodule
`default_nettype wire

// ===== bench/vgdc_router_properties.sv
// Purpose: Port checks on routing and clock control
// Assumes: Single clk_sys domain, rst active high
// Notes:   Bound into the router
`timescale 1ns/1ps
`default_nettype none
module vgdc_router_props
  import vgdc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       cyc_valid,
  input wire logic       route_valid,
  input wire logic [2:0] route_dst,
  input wire logic       mem_dll_clk_en,
  input wire logic       gfx_mem_clk_en,
  input wire logic       gfx_core_clk_en,
  input wire logic       gfx_reset_n,
  input wire logic       bridge_cfg_visible,
  input wire logic       gfx_cfg_visible,
  input wire logic       pll_div_reset,
  input wire logic       pll_sync_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_lat; cyc_valid |=> route_valid && $onehot(route_dst); endproperty
  a_lat: assert property (p_lat) else $error("late route");
  property p_idle; !cyc_valid |=> !route_valid && route_dst == 3'b000;
  endproperty
  a_idle: assert property (p_idle) else $error("stray route");
  property p_gfx; route_dst == VGDC_DST_GFX |-> gfx_core_clk_en; endproperty
  a_gfx: assert property (p_gfx) else $error("gfx not enabled");
  property p_ctl; reg_wr && reg_addr == 8'h60 |=>
    mem_dll_clk_en == !$past(reg_wdata[4]) && pll_div_reset ==
    $past(reg_wdata[1]) && gfx_mem_clk_en == !$past(reg_wdata[0]); endproperty
  a_ctl: assert property (p_ctl) else $error("clock bits");
  property p_sync; $fell(pll_div_reset) |=> pll_sync_pulse ##1 !pll_sync_pulse;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse");
  property p_cfg; gfx_cfg_visible == !bridge_cfg_visible &&
    gfx_cfg_visible == gfx_core_clk_en; endproperty
  a_cfg: assert property (p_cfg) else $error("config swap");
  property p_act; gfx_reset_n |-> gfx_core_clk_en ##1 gfx_reset_n; endproperty
  a_act: assert property (p_act) else $error("gfx reset");
  property p_prop0; reg_wr && reg_addr == 8'h60 && !reg_wdata[2] |=>
    gfx_core_clk_en == $past(gfx_core_clk_en); endproperty
  a_prop0: assert property (p_prop0) else $error("propagate zero");
endmodule
bind vgdc_router vgdc_router_props u_props (.*);
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: Self-checking bench for VGA routing and clock control
// Assumes: Decode inputs change only with a new host cycle
// Notes:   Route answer checked one cycle after the host cycle
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vgdc_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic go = 1'b0, io = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [19:0] addr = 20'h0_0000, cyc_addr;
  logic [11:0] cfg = 12'h000;
  logic [2:0] route_dst;
  logic cyc_valid, cyc_is_io, route_valid, mem_dll_clk_en, gfx_mem_clk_en;
  logic gfx_core_clk_en, gfx_reset_n, bridge_cfg_visible, gfx_cfg_visible;
  logic pll_div_reset, pll_sync_pulse;
  int mismatches = 0, comparisons = 0;
  always #20 clk_sys = ~clk_sys;
  vgdc_host_model u_host (.*);
  vgdc_router DUT (.*, .gfx_mem_space_en(cfg[11]), .gfx_io_space_en(cfg[10]),
    .gfx_in_d0(cfg[9]), .misc_output_ram_bit(cfg[8]),
    .misc_output_io_select(cfg[7]), .graphics_misc_field(cfg[6:5]),
    .bridge_mem_space_en(cfg[4]), .bridge_io_space_en(cfg[3]),
    .bridge_vga_forward(cfg[2]), .mono_adapter_present(cfg[1]),
    .bridge_isa_enable(cfg[0]));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
    if (!w) chk(reg_rdata, d);
  endtask
  task automatic rt(input logic [11:0] c, input logic i, input logic [19:0] a,
                    input logic [2:0] e);
    @(posedge clk_sys);
    cfg <= c;
    io <= i;
    addr <= a;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({route_valid, route_dst}, {1'b1, e});
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 8'h60, 8'h00);
    bus(0, 8'h70, 8'h00);
    bus(1, 8'h60, 8'h11);
    bus(1, 8'h60, 8'hff);
    bus(0, 8'h60, 8'h1f);
    chk({mem_dll_clk_en, gfx_mem_clk_en, pll_div_reset, gfx_core_clk_en},
        8'h02);
    bus(1, 8'h60, 8'h00);
    chk({mem_dll_clk_en, gfx_mem_clk_en, pll_sync_pulse}, 8'h06);
    @(posedge clk_sys);
    #1;
    chk(pll_sync_pulse, 8'h01);
    rt(12'h000, 0, 20'ha_0000, 3'h4);
    rt(12'h014, 0, 20'hb_0000, 3'h2);
    rt(12'h016, 0, 20'hb_0000, 3'h4);
    rt(12'h016, 0, 20'ha_8000, 3'h2);
    rt(12'h012, 0, 20'ha_0000, 3'h4);
    rt(12'h008, 1, 20'h0_03bc, 3'h2);
    rt(12'h009, 1, 20'h0_03bc, 3'h4);
    rt(12'h00c, 1, 20'h0_03df, 3'h2);
    rt(12'h00c, 1, 20'h0_03bc, 3'h4);
    rt(12'h00e, 1, 20'h0_03bd, 3'h4);
    rt(12'h00e, 1, 20'h0_03b0, 3'h2);
    rt(12'h00e, 1, 20'h0_03b4, 3'h4);
    rt(12'h00a, 1, 20'h0_03c0, 3'h4);
    bus(1, 8'h61, 8'h00);
    bus(1, 8'h60, 8'h08);
    chk(gfx_reset_n, 8'h00);
    bus(1, 8'h60, 8'h04);
    chk({gfx_core_clk_en, gfx_cfg_visible, bridge_cfg_visible}, 8'h06);
    bus(1, 8'h60, 8'h00);
    bus(1, 8'h60, 8'h08);
    bus(1, 8'h60, 8'h00);
    chk({gfx_reset_n, gfx_core_clk_en}, 8'h03);
    bus(0, 8'h62, 8'h03);
    rt(12'hf1c, 0, 20'hb_8000, 3'h1);
    rt(12'hf3c, 0, 20'hb_8000, 3'h2);
    rt(12'hf5c, 0, 20'hb_0000, 3'h1);
    rt(12'hf7c, 0, 20'ha_0000, 3'h2);
    rt(12'he1c, 0, 20'hb_8000, 3'h2);
    rt(12'hf1c, 1, 20'h0_03b0, 3'h1);
    rt(12'hf1c, 1, 20'h0_03d4, 3'h2);
    rt(12'hf9c, 1, 20'h0_03d4, 3'h1);
    rt(12'hf1c, 1, 20'h0_03be, 3'h4);
    rt(12'hb1c, 1, 20'h0_03c5, 3'h2);
    bus(1, 8'h61, 8'h02);
    rt(12'hf1c, 1, 20'h0_03c5, 3'h2);
    bus(0, 8'h61, 8'h02);
    give_verdict();
  end
endmodule
`default_nettype wire
